// file: mbc_coordinator.sv
// multiprocessor bus coordinator: slice arbiter, flag memory, error bits
// Contract
// R1: only granted cpu may drive the bus
// R2: each cpu gets turn as time slice
// R3: slice length fixed constant, not user set
// R4: supports one to four cpus
// R5: slot count from static jumpers or switches
// R6: installer turns on exactly one switch
// R7: shared flag memory readable and writable
// R8: 256 bytes, eight strap-masked 32-byte groups
// R9: decodes F200H..F2FFH, aligned 32-byte groups
// R10: strap present acknowledges, absent stays silent
// R11: default leaves all groups unmasked
// R12: installer masks groups used by others
// R13: extended variant adds four page frames; not built here, no page frame logic
// R14: multiprocessor mode whenever coordinator present
// R15: bus error sets cpu bit; halt release clears
// R16: grants rotate only within configured count
`timescale 1ns/1ns
`default_nettype none
`include "mbc_defines.svh"
module mbc_coordinator
   import mbc_pkg::*;
#(
   parameter int NCPU      = 4,
   parameter int SLICE_CYC = ((`MBC_SLICE_NS + `MBC_CLK_NS - 32'd1) / `MBC_CLK_NS)
) (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rstn,
   // static slot count setting
   input  wire logic        useSwitch,
   input  wire logic [1:0]  slotJumpers,
   input  wire logic        twoCpuSelect,
   input  wire logic        threeCpuSelect,
   input  wire logic        fourCpuSelect,
   // flag memory group straps, bit set = strap present
   input  wire logic [7:0]  groupStrap,
   // bus request and grant
   input  wire logic [3:0]  busRequest,
   output logic      [3:0]  busGrant,
   output logic             multiprocMode,
   // flag memory bus port
   input  wire logic [15:0] busAddr,
   input  wire logic        memRead,
   input  wire logic        memWrite,
   input  wire logic [7:0]  busWdata,
   output logic      [7:0]  busRdata,
   output logic             busAck,
   // bus monitoring
   input  wire logic [3:0]  busError,
   input  wire logic        haltActive,
   output logic      [7:0]  errorBits,
   output logic      [2:0]  cpuCount,
   output logic             configError
);
   ///////////////////////////////////////////////////////////////////////////
   localparam logic [31:0] SLICE_LAST = SLICE_CYC - 1; // R3
   localparam logic [7:0]  DEF_STRAP  = `MBC_STRAP_DEFAULT;

   function automatic logic [2:0] decode_count(input logic sw, input logic [1:0] j,
                                               input logic [2:0] s);
      logic [2:0] n;
      n = `MBC_CPU_DEFAULT;
      if (!sw) begin
         if (j == `MBC_JUMP_THREE) n = `MBC_CPU_THREE;
         else if (j == `MBC_JUMP_FOUR) n = `MBC_CPU_MAX;
         else n = `MBC_CPU_DEFAULT;
      end else begin
         if (s == `MBC_SW_THREE) n = `MBC_CPU_THREE;
         else if (s == `MBC_SW_FOUR) n = `MBC_CPU_MAX;
         else n = `MBC_CPU_DEFAULT;
      end
      return n;
   endfunction

   ///////////////////////////////////////////////////////////////////////////
   // static configuration, re-registered on every clock after reset release
   logic [2:0]  countSetting;
   logic        switchBad;
   logic [2:0]  cpuCount_reg;
   logic        configError_reg;
   logic [7:0]  strap_reg;
   assign countSetting = decode_count(useSwitch, slotJumpers,
                                      {fourCpuSelect, threeCpuSelect, twoCpuSelect}); // R5
   // more or fewer than one switch falls back to two cpus and is flagged
   assign switchBad = useSwitch &&
                      ({1'b0, twoCpuSelect} + {1'b0, threeCpuSelect} +
                       {1'b0, fourCpuSelect} != 2'd1); // R6

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cpuCount_reg <= `MBC_CPU_DEFAULT;
      end else begin
         cpuCount_reg <= countSetting; // R5
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         configError_reg <= 1'b0;
      end else begin
         configError_reg <= switchBad;
      end
   end

   // straps read as all present while reset is low
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         strap_reg <= DEF_STRAP; // R11
      end else begin
         strap_reg <= groupStrap;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // slice arbiter: fixed-length turns, the slot owns it even if idle so that
   // bus timing stays deterministic for every cpu
   logic [31:0] sliceCnt_reg;
   logic [31:0] sliceCnt_next;
   logic [1:0]  slot_reg;
   logic [1:0]  slot_next;
   logic [1:0]  slotRotate;
   logic        sliceEnd;
   logic        slotFitted;
   logic [3:0]  grantNext;
   mbc_bus_e    state_reg;
   mbc_bus_e    state_next;
   logic [2:0]  limit;

   // fewer than two fitted is allowed; slots beyond the count are skipped
   assign limit      = (cpuCount_reg > 3'(NCPU)) ? 3'(NCPU) : cpuCount_reg; // R4
   assign sliceEnd   = (sliceCnt_reg >= SLICE_LAST); // R2
   assign slotRotate = ({1'b0, slot_reg} + 3'd1 >= limit) ? 2'd0 : slot_reg + 2'd1; // R16
   // a count lowered while running must not leave a stale slot on the bus
   assign slotFitted = ({1'b0, slot_reg} < limit); // R16
   assign grantNext  = (state_reg == MBC_BUS_SLICE && slotFitted && busRequest[slot_reg])
                       ? (4'h1 << slot_reg) : 4'h0; // R1

   always_comb begin
      state_next    = state_reg;
      sliceCnt_next = sliceCnt_reg;
      slot_next     = slot_reg;
      unique case (state_reg)
         MBC_BUS_IDLE: begin
            state_next    = haltActive ? MBC_BUS_HALT : MBC_BUS_SLICE;
            sliceCnt_next = 32'd0;
         end
         MBC_BUS_SLICE: begin
            if (haltActive) begin
               state_next = MBC_BUS_HALT;
            end else if (sliceEnd) begin
               sliceCnt_next = 32'd0;
               slot_next     = slotRotate; // R2
            end else begin
               sliceCnt_next = sliceCnt_reg + 32'd1;
            end
         end
         MBC_BUS_HALT: begin
            if (!haltActive) begin
               state_next    = MBC_BUS_SLICE;
               sliceCnt_next = 32'd0;
               slot_next     = 2'd0;
            end
         end
         default: state_next = MBC_BUS_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= MBC_BUS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sliceCnt_reg <= 32'd0;
         slot_reg     <= 2'd0;
      end else begin
         sliceCnt_reg <= sliceCnt_next;
         slot_reg     <= slot_next;
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // flag memory: 256 bytes of flops, acknowledge gated per group strap
   logic [7:0] flagMem [0:255];
   logic       inRange;
   logic [2:0] group;
   logic       groupOpen;
   logic       access;
   logic       readHit;
   logic       writeHit;
   logic [7:0] index;
   logic [7:0] rdataNext;
   assign inRange   = (busAddr[15:`MBC_ADDR_HI_LSB] == `MBC_FLAG_TOP); // R9
   assign index     = busAddr[7:0]; // R8
   assign group     = index[7:`MBC_GROUP_LSB]; // R9
   assign groupOpen = strap_reg[group]; // R10
   assign access    = inRange && groupOpen && (memRead || memWrite); // R10
   assign readHit   = access && memRead;
   assign writeHit  = access && memWrite;
   // a read returns the byte as it stood before a write in the same cycle
   assign rdataNext = readHit ? flagMem[index] : 8'h00; // R7

   always_ff @(posedge mclk) begin
      if (writeHit) begin
         flagMem[index] <= busWdata; // R7
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // error bits; a new error wins over the clear on halt release
   logic [7:0] err_reg;
   logic       haltPrev_reg;
   logic       haltRelease;
   logic [7:0] errSet;
   assign haltRelease = haltPrev_reg && !haltActive;

   // only cpus below NCPU own an error bit, whatever the configured count
   always_comb begin
      errSet = 8'h00;
      for (int c = 0; c < NCPU; c++) begin
         errSet[c] = busError[c]; // R15
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         haltPrev_reg <= 1'b0;
      end else begin
         haltPrev_reg <= haltActive;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         err_reg <= 8'h00;
      end else begin
         err_reg <= (haltRelease ? 8'h00 : err_reg) | errSet; // R15
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busGrant <= 4'h0;
      end else begin
         busGrant <= grantNext; // R1
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busAck <= 1'b0;
      end else begin
         busAck <= access; // R10
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         busRdata <= 8'h00;
      end else begin
         busRdata <= rdataNext;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         multiprocMode <= 1'b0;
      end else begin
         multiprocMode <= 1'b1; // R14
      end
   end
   assign errorBits   = err_reg;
   assign cpuCount    = cpuCount_reg;
   assign configError = configError_reg;
endmodule
`default_nettype wire

// file: mbc_coordinator_assertions.sv
// port checker for the bus coordinator
`timescale 1ns/1ns
`default_nettype none
module mbc_coordinator_assertions (
   input wire logic        mclk,
   input wire logic        rstn,
   input wire logic [7:0]  groupStrap,
   input wire logic [3:0]  busRequest,
   input wire logic [3:0]  busGrant,
   input wire logic        multiprocMode,
   input wire logic [15:0] busAddr,
   input wire logic        memRead,
   input wire logic        memWrite,
   input wire logic [7:0]  busRdata,
   input wire logic        busAck,
   input wire logic [3:0]  busError,
   input wire logic        haltActive,
   input wire logic [7:0]  errorBits,
   input wire logic [2:0]  cpuCount
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   logic [7:0] strapSeen;
   // straps act one clock late and read as all present out of reset
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) strapSeen <= 8'hFF;
      else strapSeen <= groupStrap;
   end
   wire hit = (memRead | memWrite) && busAddr[15:8] == 8'hF2 && strapSeen[busAddr[7:5]];
   grant_one_hot_a: assert property ($onehot0(busGrant)) else $error("two grants");
   grant_has_req_a: assert property (busGrant != 4'h0 |->
      (busGrant & $past(busRequest)) != 4'h0) else $error("grant without request");
   count_limit_a: assert property (busGrant < (5'h01 << cpuCount)) else $error("slot over");
   ack_hit_a: assert property (hit |=> busAck) else $error("no ack");
   ack_cause_a: assert property (busAck |-> $past(hit)) else $error("stray ack");
   rdata_idle_a: assert property (!busAck |-> busRdata == 8'h00) else $error("rdata");
   err_set_a: assert property (busError != 4'h0 |=>
      (errorBits[3:0] & $past(busError)) == $past(busError)) else $error("error bit lost");
   err_clear_a: assert property (($fell(haltActive) && busError == 4'h0) ##1
      busError == 4'h0 |=> errorBits == 8'h00) else $error("error bits kept");
   mp_mode_a: assert property ($past(rstn) |-> multiprocMode) else $error("single mode");
   cover property (busAck && busRdata != 8'h00);
   cover property (busGrant[3]);
   cover property (errorBits != 8'h00);
endmodule
bind mbc_coordinator mbc_coordinator_assertions mbc_coordinator_assertions_i (.mclk(mclk),
   .rstn(rstn), .groupStrap(groupStrap), .busRequest(busRequest), .busGrant(busGrant),
   .multiprocMode(multiprocMode), .busAddr(busAddr), .memRead(memRead), .memWrite(memWrite),
   .busRdata(busRdata), .busAck(busAck), .busError(busError), .haltActive(haltActive),
   .errorBits(errorBits), .cpuCount(cpuCount));
`default_nettype wire

// file: mbc_cpu_model.sv
// cpus on the backplane asking for bus slices
`timescale 1ns/1ns
`default_nettype none
module mbc_cpu_model (
   input wire logic       mclk,
   input wire logic [3:0] cpuWant,
   input wire logic       slow,
   output logic     [3:0] busRequest
);
   logic [3:0] lagReg;
   // each cpu asks as cpuWant says, one negedge later when slow
   always @(negedge mclk) begin
      lagReg <= cpuWant;
      busRequest <= slow ? lagReg : cpuWant;
   end
endmodule
`default_nettype wire

// file: mbc_defines.svh
// constants for the multiprocessor bus coordinator
`ifndef MBC_DEFINES_SVH
`define MBC_DEFINES_SVH
`define MBC_SLICE_NS      32'd4000
`define MBC_CLK_NS        32'd4
`define MBC_FLAG_BASE     16'hF200
`define MBC_FLAG_TOP      8'hF2
`define MBC_GROUP_LSB     5
`define MBC_ADDR_HI_LSB   8
`define MBC_CPU_MAX       3'h4
`define MBC_CPU_DEFAULT   3'h2
`define MBC_CPU_THREE     3'h3
`define MBC_STRAP_DEFAULT 8'hFF
`define MBC_JUMP_TWO      2'h3
`define MBC_JUMP_THREE    2'h1
`define MBC_JUMP_FOUR     2'h2
`define MBC_SW_TWO        3'h1
`define MBC_SW_THREE      3'h2
`define MBC_SW_FOUR       3'h4
`endif

// file: mbc_pkg.sv
// types for the multiprocessor bus coordinator
package mbc_pkg;
   typedef enum logic [1:0] {
      MBC_BUS_IDLE  = 2'b00,
      MBC_BUS_SLICE = 2'b01,
      MBC_BUS_HALT  = 2'b10
   } mbc_bus_e;
endpackage

// file: multiprocessor_bus_coordinator_test.sv
// self-checking bench for the bus coordinator
`timescale 1ns/1ns
`default_nettype none
module multiprocessor_bus_coordinator_test;
   logic mclk = 1'b0, rstn = 1'b0, useSwitch = 1'b0, memRead = 1'b0, memWrite = 1'b0;
   logic twoCpuSelect = 1'b0, threeCpuSelect = 1'b0, fourCpuSelect = 1'b0;
   logic haltActive = 1'b0, slow = 1'b0, busAck, multiprocMode, configError;
   logic [1:0] slotJumpers = 2'h3;
   logic [2:0] cpuCount;
   logic [3:0] busError = 4'h0, cpuWant = 4'hF, busRequest, busGrant;
   logic [7:0] groupStrap = 8'hFF, busWdata = 8'h00, seen, busRdata, errorBits;
   logic [15:0] busAddr = 16'h0000;
   logic [5:0] cf [8] = '{6'h18, 6'h08, 6'h10, 6'h21, 6'h22, 6'h24, 6'h23, 6'h00};
   int nx [8] = '{2, 3, 4, 2, 3, 4, 2, 2};
   int n_mismatch = 0, checks_done = 0, cyc = 0, hold = 0;
   localparam int SLICE = 8;
   always #2 mclk = ~mclk;
   mbc_cpu_model mbc_cpu_model_i (.mclk(mclk), .cpuWant(cpuWant), .slow(slow),
      .busRequest(busRequest));
   mbc_coordinator #(.SLICE_CYC(SLICE)) mbc_coordinator_i (.mclk(mclk), .rstn(rstn),
      .useSwitch(useSwitch), .slotJumpers(slotJumpers), .twoCpuSelect(twoCpuSelect),
      .threeCpuSelect(threeCpuSelect), .fourCpuSelect(fourCpuSelect), .groupStrap(groupStrap),
      .busRequest(busRequest), .busGrant(busGrant), .multiprocMode(multiprocMode),
      .busAddr(busAddr), .memRead(memRead), .memWrite(memWrite), .busWdata(busWdata),
      .busRdata(busRdata), .busAck(busAck), .busError(busError), .haltActive(haltActive),
      .errorBits(errorBits), .cpuCount(cpuCount), .configError(configError));
   task chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // config only moves under reset, so no grant can outlive a shrinking count
   task rst(input logic [5:0] c);
      rstn = 1'b0;
      {useSwitch, slotJumpers, fourCpuSelect, threeCpuSelect, twoCpuSelect} = c;
      repeat (16) @(negedge mclk);
      rstn = 1'b1;
   endtask
   // strobes stay up into the next call, giving back-to-back accesses
   task acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] ex);
      {memWrite, memRead, busAddr, busWdata} = {w, !w, a, d};
      @(negedge mclk);
      chk({7'h00, busAck}, {7'h00, ex[8]});
      if (!w) chk(busRdata, ex[7:0]);
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         conclude;
      end
   end
   initial begin
      rst(6'h18);
      groupStrap = 8'hA5;
      for (int g = 0; g < 8; g++)
         acc(1'b1, 16'hF200 + 16'(g * 33), 8'(g + 1), {groupStrap[g], 8'h00});
      for (int g = 0; g < 8; g++)
         acc(1'b0, 16'hF200 + 16'(g * 33), 8'h00, groupStrap[g] ? {1'b1, 8'(g + 1)} : 9'h000);
      acc(1'b1, 16'hF2FF, 8'h3C, 9'h100);
      acc(1'b0, 16'hF2FF, 8'h00, 9'h13C);
      acc(1'b0, 16'hF300, 8'h00, 9'h000);
      acc(1'b0, 16'hF1FF, 8'h00, 9'h000);
      {memRead, memWrite} = 2'h0;
      $display("flag memory test done");
      for (int i = 0; i < 8; i++) begin
         slow = i[0];
         cpuWant = (i == 7) ? 4'hD : 4'hF;
         rst(cf[i]);
         seen = 8'h00;
         hold = 0;
         for (int k = 0; k < 80; k++) begin
            @(negedge mclk);
            seen |= {4'h0, busGrant};
            if (k < 2 * SLICE) hold += busGrant[0];
         end
         chk({5'h00, cpuCount}, 8'(nx[i]));
         chk({7'h00, configError}, {7'h00, i == 6});
         chk(seen, 8'((1 << nx[i]) - 1) & {4'h0, cpuWant});
         chk(8'(hold), 8'(SLICE));
      end
      $display("arbiter test done");
      busError = 4'h5;
      haltActive = 1'b1;
      @(negedge mclk);
      busError = 4'h0;
      repeat (2) @(negedge mclk);
      chk(errorBits, 8'h05);
      chk({4'h0, busGrant}, 8'h00);
      haltActive = 1'b0;
      repeat (3) @(negedge mclk);
      chk(errorBits, 8'h00);
      chk({7'h00, multiprocMode}, 8'h01);
      chk({4'h0, busGrant}, 8'h01);
      haltActive = 1'b1;
      @(negedge mclk);
      {haltActive, busError} = {1'b0, 4'h2};
      @(negedge mclk);
      busError = 4'h0;
      @(negedge mclk);
      chk(errorBits, 8'h02);
      $display("error test done");
      conclude;
   end
endmodule
`default_nettype wire
